// ### verilog/epm_position_monitor.sv
`timescale 1ns/1ps

module epm_position_monitor #(
   parameter int NUM_EXTRACTORS = 4
) (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   // encoder sample
   input  wire logic        sample_valid_in,
   input  wire logic [31:0] encoder_value_in,
   input  wire logic [31:0] encoder_frame_in,
   // register write and read
   input  wire logic        reg_write_in,
   input  wire logic [5:0]  reg_write_index_in,
   input  wire logic [31:0] reg_write_data_in,
   input  wire logic [5:0]  reg_read_index_in,
   output logic [31:0]      reg_read_data_out,
   // process output data
   input  wire logic [1:0]  compare_enable_in,
   input  wire logic [1:0]  compare_latch_clear_in,
   // process input data
   output logic [31:0]      corrected_position_out,
   output logic [1:0]       compare_at_or_above_out,
   output logic [1:0]       compare_match_out,
   output logic [1:0]       compare_hit_latch_out,
   output logic             above_upper_bound_out,
   output logic             below_lower_bound_out,
   output logic [3:0]       frame_status_bit_out,
   output logic             encoder_group_fault_out,
   // diagnostics
   output logic             diag_group_out,
   output logic             diag_overflow_out,
   output logic             diag_underflow_out
);

   // -----------------------------------------------------------------
   // parameter check
   // -----------------------------------------------------------------
   if (NUM_EXTRACTORS < 1 || NUM_EXTRACTORS > epm_pkg::MAX_EXTRACTORS) begin : g_bad_count
      $error("NUM_EXTRACTORS must lie between 1 and 4");
   end

   // a five-bit index reaches every bit of a 32-bit frame, no further
   if (epm_pkg::PICK_INDEX_WIDTH > 5) begin : g_bad_index
      $error("frame bit index wider than the frame needs");
   end

   // control bits must sit inside their extractor byte
   if (epm_pkg::PICK_COPY_BIT >= epm_pkg::PICK_BYTE_WIDTH ||
       epm_pkg::PICK_DIAG_BIT >= epm_pkg::PICK_BYTE_WIDTH) begin : g_bad_layout
      $error("extractor control bit outside its byte");
   end

   // all extractor bytes share one 32-bit pick word
   if (epm_pkg::MAX_EXTRACTORS * epm_pkg::PICK_BYTE_WIDTH > 32) begin : g_bad_map
      $error("extractor bytes do not fit the pick word");
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [7:0] pick_byte(input logic [31:0] map, input int n);
      pick_byte = map[n*epm_pkg::PICK_BYTE_WIDTH +: epm_pkg::PICK_BYTE_WIDTH];
   endfunction

   function automatic logic select_bit(input logic [31:0] frame, input logic [7:0] cfg);
      select_bit = frame[cfg[epm_pkg::PICK_INDEX_LSB +: epm_pkg::PICK_INDEX_WIDTH]];
   endfunction

   // write strobe aimed at one register index
   function automatic logic write_hit(input logic       wr,
                                      input logic [5:0] idx,
                                      input logic [5:0] target);
      write_hit = wr && (idx == target);
   endfunction

   // -----------------------------------------------------------------
   // stored registers
   // -----------------------------------------------------------------
   logic [31:0] compare_value [2];
   logic [31:0] upper_bound;
   logic [31:0] lower_bound;
   logic [31:0] position_shift;
   logic [31:0] frame_bit_pick;
   logic [31:0] raw_frame;

   // read-only indices match none of these and so are ignored
   wire wr_cmp0  = write_hit(reg_write_in, reg_write_index_in, epm_pkg::IDX_COMPARE_VALUE_0);
   wire wr_cmp1  = write_hit(reg_write_in, reg_write_index_in, epm_pkg::IDX_COMPARE_VALUE_1);
   wire wr_lower = write_hit(reg_write_in, reg_write_index_in, epm_pkg::IDX_LOWER_BOUND);
   wire wr_upper = write_hit(reg_write_in, reg_write_index_in, epm_pkg::IDX_UPPER_BOUND);
   wire wr_shift = write_hit(reg_write_in, reg_write_index_in, epm_pkg::IDX_POSITION_SHIFT);
   wire wr_pick  = write_hit(reg_write_in, reg_write_index_in, epm_pkg::IDX_FRAME_BIT_PICK);

   // compare value 0
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         compare_value[0] <= epm_pkg::RST_COMPARE_VALUE;
      end else if (wr_cmp0) begin
         compare_value[0] <= reg_write_data_in;
      end
   end

   // compare value 1
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         compare_value[1] <= epm_pkg::RST_COMPARE_VALUE;
      end else if (wr_cmp1) begin
         compare_value[1] <= reg_write_data_in;
      end
   end

   // lower bound, zero keeps its monitor idle
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         lower_bound <= epm_pkg::RST_LOWER_BOUND;
      end else if (wr_lower) begin
         lower_bound <= reg_write_data_in;
      end
   end

   // upper bound, all ones keeps its monitor idle
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         upper_bound <= epm_pkg::RST_UPPER_BOUND;
      end else if (wr_upper) begin
         upper_bound <= reg_write_data_in;
      end
   end

   // position shift
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         position_shift <= epm_pkg::RST_POSITION_SHIFT;
      end else if (wr_shift) begin
         position_shift <= reg_write_data_in;
      end
   end

   // extractor map, one byte per extractor
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         frame_bit_pick <= epm_pkg::RST_FRAME_BIT_PICK;
      end else if (wr_pick) begin
         frame_bit_pick <= reg_write_data_in;
      end
   end

   // -----------------------------------------------------------------
   // offset correction and frame capture
   // -----------------------------------------------------------------
   // a zero shift subtracts nothing, so the raw value passes unchanged
   wire [31:0] next_corrected_position = encoder_value_in - position_shift;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         corrected_position_out <= 32'h00000000;
      end else if (sample_valid_in) begin
         corrected_position_out <= next_corrected_position;
      end
   end

   // the whole frame is kept for the status bit extractors
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         raw_frame <= 32'h00000000;
      end else if (sample_valid_in) begin
         raw_frame <= encoder_frame_in;
      end
   end

   // -----------------------------------------------------------------
   // comparators
   // -----------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_cmp
      // unsigned compare against the corrected position only
      wire at_or_above = (corrected_position_out >= compare_value[c]);
      wire equal      = (corrected_position_out == compare_value[c]);

      always_ff @(posedge core_clk_in) begin
         if (!rst_n_in) begin
            compare_at_or_above_out[c] <= 1'b0;
            compare_match_out[c]       <= 1'b0;
            compare_hit_latch_out[c]   <= 1'b0;
         end else if (!compare_enable_in[c]) begin
            compare_at_or_above_out[c] <= 1'b0;
            compare_match_out[c]       <= 1'b0;
            compare_hit_latch_out[c]   <= 1'b0;
         end else begin
            compare_at_or_above_out[c] <= at_or_above;
            compare_match_out[c]       <= equal;
            // equality wins over the clear
            if (equal) begin
               compare_hit_latch_out[c] <= 1'b1;
            end else if (compare_latch_clear_in[c]) begin
               compare_hit_latch_out[c] <= 1'b0;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // bound monitors
   // -----------------------------------------------------------------
   wire upper_active = (upper_bound != epm_pkg::RST_UPPER_BOUND);
   wire lower_active = (lower_bound != epm_pkg::RST_LOWER_BOUND);
   wire next_above   = upper_active && (corrected_position_out > upper_bound);
   wire next_below   = lower_active && (corrected_position_out < lower_bound);

   // overflow side
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         above_upper_bound_out <= 1'b0;
         diag_overflow_out     <= 1'b0;
      end else begin
         above_upper_bound_out <= next_above;
         diag_overflow_out     <= next_above;
      end
   end

   // underflow side
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         below_lower_bound_out <= 1'b0;
         diag_underflow_out    <= 1'b0;
      end else begin
         below_lower_bound_out <= next_below;
         diag_underflow_out    <= next_below;
      end
   end

   // -----------------------------------------------------------------
   // status bit extractors
   // -----------------------------------------------------------------
   logic [3:0] picked_bit;
   logic [3:0] diag_term;

   for (genvar e = 0; e < epm_pkg::MAX_EXTRACTORS; e++) begin : g_pick
      if (e < NUM_EXTRACTORS) begin : g_on
         wire [7:0] cfg = pick_byte(frame_bit_pick, e);
         wire       sel = select_bit(raw_frame, cfg);
         // a disabled copy reads zero and so cannot raise the group fault
         assign picked_bit[e] = cfg[epm_pkg::PICK_COPY_BIT] & sel;
         assign diag_term[e]  = picked_bit[e] & cfg[epm_pkg::PICK_DIAG_BIT];
      end else begin : g_off
         assign picked_bit[e] = 1'b0;
         assign diag_term[e]  = 1'b0;
      end
   end

   wire next_group_fault = |diag_term;

   // copied status bits for the process input data
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         frame_status_bit_out <= 4'h0;
      end else begin
         frame_status_bit_out <= picked_bit;
      end
   end

   // group fault, shown both in process data and on the diagnostics channel
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         encoder_group_fault_out <= 1'b0;
         diag_group_out          <= 1'b0;
      end else begin
         encoder_group_fault_out <= next_group_fault;
         diag_group_out          <= next_group_fault;
      end
   end

   // -----------------------------------------------------------------
   // register read port
   // -----------------------------------------------------------------
   logic [31:0] next_read_data;

   always_comb begin
      unique case (reg_read_index_in)
         epm_pkg::IDX_CORRECTED_POSITION: next_read_data = corrected_position_out;
         epm_pkg::IDX_RAW_FRAME:          next_read_data = raw_frame;
         epm_pkg::IDX_COMPARE_VALUE_0:    next_read_data = compare_value[0];
         epm_pkg::IDX_COMPARE_VALUE_1:    next_read_data = compare_value[1];
         epm_pkg::IDX_LOWER_BOUND:        next_read_data = lower_bound;
         epm_pkg::IDX_UPPER_BOUND:        next_read_data = upper_bound;
         epm_pkg::IDX_POSITION_SHIFT:     next_read_data = position_shift;
         epm_pkg::IDX_FRAME_BIT_PICK:     next_read_data = frame_bit_pick;
         default:                         next_read_data = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         reg_read_data_out <= 32'h00000000;
      end else begin
         reg_read_data_out <= next_read_data;
      end
   end

endmodule // epm_position_monitor

// ### verilog/epm_pkg.sv
package epm_pkg;

   // -----------------------------------------------------------------
   // register indices
   // -----------------------------------------------------------------
   localparam logic [5:0] IDX_CORRECTED_POSITION = 6'h00;
   localparam logic [5:0] IDX_RAW_FRAME          = 6'h21;
   localparam logic [5:0] IDX_COMPARE_VALUE_0    = 6'h22;
   localparam logic [5:0] IDX_COMPARE_VALUE_1    = 6'h23;
   localparam logic [5:0] IDX_LOWER_BOUND        = 6'h30;
   localparam logic [5:0] IDX_UPPER_BOUND        = 6'h31;
   localparam logic [5:0] IDX_POSITION_SHIFT     = 6'h32;
   localparam logic [5:0] IDX_FRAME_BIT_PICK     = 6'h33;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [31:0] RST_UPPER_BOUND    = 32'hFFFFFFFF;
   localparam logic [31:0] RST_LOWER_BOUND    = 32'h00000000;
   localparam logic [31:0] RST_POSITION_SHIFT = 32'h00000000;
   localparam logic [31:0] RST_COMPARE_VALUE  = 32'h00000000;
   localparam logic [31:0] RST_FRAME_BIT_PICK = 32'h00000000;

   // -----------------------------------------------------------------
   // extractor byte layout
   // -----------------------------------------------------------------
   localparam int PICK_BYTE_WIDTH   = 8;
   localparam int PICK_INDEX_LSB    = 0;
   localparam int PICK_INDEX_WIDTH  = 5;
   localparam int PICK_DIAG_BIT     = 6;
   localparam int PICK_COPY_BIT     = 7;
   localparam int MAX_EXTRACTORS    = 4;

endpackage

// ### testbench/epm_app_model.sv
`timescale 1ns/1ps
module epm_app_model (
   // clock
   input  wire logic       core_clk_in,
   // commands from the test sequence
   input  wire logic [1:0] enable_cmd_in,
   input  wire logic [1:0] clear_cmd_in,
   // process output data
   output logic [1:0]      compare_enable_out,
   output logic [1:0]      compare_latch_clear_out
);
   // output image refreshed once per cycle
   always_ff @(posedge core_clk_in) begin
      compare_enable_out      <= enable_cmd_in;
      compare_latch_clear_out <= clear_cmd_in;
   end
endmodule // epm_app_model

// ### testbench/epm_properties.sv
`timescale 1ns/1ps
module epm_props (
   // clock and reset
   input wire logic        core_clk_in,
   input wire logic        rst_n_in,
   // inputs watched
   input wire logic        sample_valid_in,
   input wire logic [1:0]  compare_enable_in,
   input wire logic [1:0]  compare_latch_clear_in,
   // outputs watched
   input wire logic [31:0] corrected_position_out,
   input wire logic [1:0]  compare_at_or_above_out,
   input wire logic [1:0]  compare_match_out,
   input wire logic [1:0]  compare_hit_latch_out,
   input wire logic        above_upper_bound_out,
   input wire logic        below_lower_bound_out,
   input wire logic        encoder_group_fault_out,
   input wire logic        diag_group_out,
   input wire logic        diag_overflow_out,
   input wire logic        diag_underflow_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_off0; !compare_enable_in[0]; endsequence
   sequence s_hit_rise0; $rose(compare_hit_latch_out[0]); endsequence
   property p_off; s_off0 |=> (compare_at_or_above_out[0] | compare_match_out[0]
      | compare_hit_latch_out[0]) == 1'b0; endproperty
   property p_rel; (compare_match_out & ~compare_at_or_above_out) == 2'h0; endproperty
   property p_mhit; (compare_match_out & ~compare_hit_latch_out) == 2'h0; endproperty
   property p_hit1; compare_hit_latch_out[1] == ($past(compare_enable_in[1]) &&
      (compare_match_out[1] || ($past(compare_hit_latch_out[1]) &&
      !$past(compare_latch_clear_in[1])))); endproperty
   property p_set; s_hit_rise0 |-> compare_match_out[0]; endproperty
   property p_stay; compare_hit_latch_out[0] && compare_enable_in[0] &&
      !compare_latch_clear_in[0] |=> compare_hit_latch_out[0]; endproperty
   property p_ovf; diag_overflow_out == above_upper_bound_out; endproperty
   property p_unf; diag_underflow_out == below_lower_bound_out; endproperty
   property p_grp; diag_group_out == encoder_group_fault_out; endproperty
   property p_hold; !sample_valid_in |=> $stable(corrected_position_out); endproperty
   a_off: assert property (p_off) else $error("comparator active while off");
   a_rel: assert property (p_rel) else $error("match without at-or-above");
   a_mhit: assert property (p_mhit) else $error("match without hit latch");
   a_hit1: assert property (p_hit1) else $error("hit latch one wrong");
   a_set: assert property (p_set) else $error("latch set without match");
   a_stay: assert property (p_stay) else $error("hit latch dropped");
   a_ovf: assert property (p_ovf) else $error("overflow diag differs");
   a_unf: assert property (p_unf) else $error("underflow diag differs");
   a_grp: assert property (p_grp) else $error("group diag differs");
   a_hold: assert property (p_hold) else $error("position moved without sample");
endmodule // epm_props
bind epm_position_monitor epm_props u_props (.*);

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        core_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        sample_valid_in = 1'b0;
   logic [31:0] encoder_value_in = 32'h0;
   logic [31:0] encoder_frame_in = 32'h0;
   logic        reg_write_in = 1'b0;
   logic [5:0]  reg_write_index_in = 6'h0;
   logic [31:0] reg_write_data_in = 32'h0;
   logic [5:0]  reg_read_index_in = 6'h0;
   logic [1:0]  en_cmd = 2'h0;
   logic [1:0]  clr_cmd = 2'h0;
   logic [31:0] reg_read_data_out, corrected_position_out;
   logic [1:0]  compare_enable_in, compare_latch_clear_in, compare_at_or_above_out;
   logic [1:0]  compare_match_out, compare_hit_latch_out;
   logic [3:0]  frame_status_bit_out;
   logic        above_upper_bound_out, below_lower_bound_out, encoder_group_fault_out;
   logic        diag_group_out, diag_overflow_out, diag_underflow_out;
   int          err_total = 0;
   int          checked = 0;
   int          cycles = 0;
   wire  [9:0]  flg = {compare_at_or_above_out, compare_match_out, compare_hit_latch_out,
      above_upper_bound_out, below_lower_bound_out, diag_overflow_out, diag_underflow_out};
   wire  [5:0]  sts = {frame_status_bit_out, encoder_group_fault_out, diag_group_out};
   always #20 core_clk_in = ~core_clk_in;
   epm_position_monitor dut_u (.core_clk_in, .rst_n_in, .sample_valid_in, .encoder_value_in,
      .encoder_frame_in, .reg_write_in, .reg_write_index_in, .reg_write_data_in,
      .reg_read_index_in, .reg_read_data_out, .compare_enable_in, .compare_latch_clear_in,
      .corrected_position_out, .compare_at_or_above_out, .compare_match_out,
      .compare_hit_latch_out, .above_upper_bound_out, .below_lower_bound_out,
      .frame_status_bit_out, .encoder_group_fault_out, .diag_group_out, .diag_overflow_out,
      .diag_underflow_out);
   epm_app_model app_u (.core_clk_in, .enable_cmd_in(en_cmd), .clear_cmd_in(clr_cmd),
      .compare_enable_out(compare_enable_in), .compare_latch_clear_out(compare_latch_clear_in));
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      reg_write_in = 1'b1;
      reg_write_index_in = idx;
      reg_write_data_in = d;
      step(1);
      reg_write_in = 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
      reg_read_index_in = idx;
      step(1);
      chk(reg_read_data_out, exp);
   endtask
   task automatic smp(input logic [31:0] v, input logic [31:0] f);
      sample_valid_in = 1'b1;
      encoder_value_in = v;
      encoder_frame_in = f;
      step(1);
      sample_valid_in = 1'b0;
      step(2);
   endtask
   task automatic app(input logic [1:0] e, input logic [1:0] c);
      en_cmd = e;
      clr_cmd = c;
      step(4);
   endtask
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      step(10);
      rst_n_in = 1'b1;
      rd(epm_pkg::IDX_UPPER_BOUND, 32'hFFFFFFFF);
      rd(epm_pkg::IDX_LOWER_BOUND, 32'h0);
      rd(6'h3F, 32'h0);
      wr(epm_pkg::IDX_CORRECTED_POSITION, 32'h1234);
      rd(epm_pkg::IDX_CORRECTED_POSITION, 32'h0);
      wr(epm_pkg::IDX_POSITION_SHIFT, 32'h5);
      smp(32'h2, 32'h0);
      chk(corrected_position_out, 32'h2 - 32'h5);
      chk({22'h0, flg}, 32'h0);
      wr(epm_pkg::IDX_COMPARE_VALUE_0, 32'h5F);
      wr(epm_pkg::IDX_COMPARE_VALUE_1, 32'h64);
      rd(epm_pkg::IDX_COMPARE_VALUE_0, 32'h5F);
      app(2'h3, 2'h0);
      smp(32'h64, 32'h0);
      chk({22'h0, flg}, 32'h150);
      app(2'h3, 2'h3);
      chk({22'h0, flg}, 32'h150);
      app(2'h3, 2'h0);
      smp(32'h6A, 32'h0);
      chk({22'h0, flg}, 32'h310);
      smp(32'h69, 32'h0);
      chk({22'h0, flg}, 32'h3B0);
      smp(32'h5, 32'h0);
      chk({22'h0, flg}, 32'h030);
      app(2'h3, 2'h1);
      chk({22'h0, flg}, 32'h020);
      app(2'h1, 2'h0);
      chk({22'h0, flg}, 32'h0);
      wr(epm_pkg::IDX_POSITION_SHIFT, 32'h0);
      smp(32'h5F, 32'h0);
      chk(corrected_position_out, 32'h5F);
      chk({22'h0, flg}, 32'h150);
      app(2'h0, 2'h0);
      wr(epm_pkg::IDX_UPPER_BOUND, 32'h50);
      step(2);
      chk({22'h0, flg}, 32'h00A);
      wr(epm_pkg::IDX_UPPER_BOUND, 32'h5F);
      step(2);
      chk({22'h0, flg}, 32'h0);
      wr(epm_pkg::IDX_LOWER_BOUND, 32'h60);
      step(2);
      chk({22'h0, flg}, 32'h005);
      wr(epm_pkg::IDX_LOWER_BOUND, 32'h5F);
      step(2);
      chk({22'h0, flg}, 32'h0);
      wr(epm_pkg::IDX_FRAME_BIT_PICK, 32'hA0429FC2);
      smp(32'h5F, 32'h80000004);
      chk({26'h0, sts}, 32'h0F);
      rd(epm_pkg::IDX_RAW_FRAME, 32'h80000004);
      wr(epm_pkg::IDX_FRAME_BIT_PICK, 32'hA0429F82);
      step(2);
      chk({26'h0, sts}, 32'h0C);
      rd(epm_pkg::IDX_FRAME_BIT_PICK, 32'hA0429F82);
      rst_n_in = 1'b0;
      step(2);
      rst_n_in = 1'b1;
      rd(epm_pkg::IDX_UPPER_BOUND, 32'hFFFFFFFF);
      chk({26'h0, sts}, 32'h0);
      test_done();
   end
endmodule // testbench
